// ---- core/qos_sched_pkg.sv ----
package qos_sched_pkg;
    localparam int unsigned NUM_Q = 4;
    localparam int unsigned Q_DEPTH = 4;
    localparam int unsigned NUM_PORTS = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned SEQ_W = 6;
    localparam int unsigned BUF_DEPTH = 2;

    // register byte addresses
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_WEIGHT = 8'h04;
    localparam logic [7:0] ADDR_MAP = 8'h08;
    localparam logic [7:0] ADDR_PORT_PRI = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    typedef enum logic [1:0] {
        MODE_FCFS = 2'b00,
        MODE_STRICT = 2'b01,
        MODE_WRR = 2'b10
    } sched_mode_t;

    // queue index 3 is highest, 0 lowest
    localparam logic [1:0] Q_LOWEST = 2'h0;
    localparam logic [1:0] Q_HIGHEST = 2'h3;

    localparam sched_mode_t MODE_RST = MODE_WRR;
    localparam logic [15:0] WEIGHT_RST = 16'h8421;
    localparam logic [15:0] MAP_RST = 16'hFA50;
    localparam logic [3:0] PORT_PRI_RST = 4'h0;

    // port priority command fields and status buffer count position
    localparam int unsigned PP_EN_BIT = 3;
    localparam int unsigned PP_PORT_LSB = 4;
    localparam int unsigned PP_SEL_BIT = 7;
    localparam int unsigned STAT_BUF_LSB = 16;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : qos_sched_pkg

// ---- core/egress_qos_queue_scheduler.sv ----
`timescale 1ns/1ps
module egress_qos_queue_scheduler
    import qos_sched_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // packets from forwarding engine
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [DATA_W-1:0] in_data,
    input wire logic in_tagged,
    input wire logic [2:0] in_tag_pri,
    input wire logic [2:0] in_port,
    // packets to transmit MAC
    output logic out_valid,
    input wire logic out_ready,
    output logic [DATA_W-1:0] out_data,
    output logic [1:0] out_queue
);
    sched_mode_t mode_r;
    logic [15:0] weight_r, map_r;
    logic [3:0] port_pri_r [NUM_PORTS];
    logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r, rdata_nxt, wmask;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r, rresp_nxt;
    logic wr_do;
    logic [DATA_W-1:0] q_data [NUM_Q][Q_DEPTH];
    logic [SEQ_W-1:0] q_seq [NUM_Q][Q_DEPTH];
    logic [1:0] q_wp_r [NUM_Q];
    logic [1:0] q_rp_r [NUM_Q];
    logic [2:0] q_cnt_r [NUM_Q];
    logic [SEQ_W-1:0] q_age [NUM_Q];
    logic [NUM_Q-1:0] q_busy;
    logic [SEQ_W-1:0] seq_r;
    logic [2:0] in_pri;
    logic [1:0] enq_q, sel_q, cur_r, idx;
    logic enq_fire, deq_fire, sel_valid, sel_fresh;
    logic [3:0] cnt_r;
    logic [DATA_W-1:0] buf_data [BUF_DEPTH];
    logic [1:0] buf_qid [BUF_DEPTH];
    logic buf_wp_r, buf_rp_r, buf_in_ready;
    logic [1:0] buf_cnt_r;

    default clocking sva_clk @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // register bus slave
    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready = !w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign wr_do = aw_held_r && w_held_r && !bvalid_r;
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{wstrb_r[b]}};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held_r) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_r) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= (awaddr_r > ADDR_STATUS || awaddr_r[1:0] != 2'h0)
                    ? RESP_DECERR : RESP_OKAY;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= MODE_RST;
            weight_r <= WEIGHT_RST;
            map_r <= MAP_RST;
        end else if (wr_do) begin
            if (awaddr_r == ADDR_MODE && wstrb_r[0]
                    && s_axi_wdata_ok(wdata_r[1:0])) begin
                mode_r <= sched_mode_t'(wdata_r[1:0]);
            end
            if (awaddr_r == ADDR_WEIGHT) begin
                weight_r <= (weight_r & ~wmask[15:0])
                    | (wdata_r[15:0] & wmask[15:0]);
            end
            if (awaddr_r == ADDR_MAP) begin
                map_r <= (map_r & ~wmask[15:0])
                    | (wdata_r[15:0] & wmask[15:0]);
            end
        end
    end

    function automatic logic s_axi_wdata_ok(input logic [1:0] m);
        return m != 2'b11;
    endfunction : s_axi_wdata_ok

    // static ingress priority per port
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                port_pri_r[p] <= PORT_PRI_RST;
            end else if (wr_do && awaddr_r == ADDR_PORT_PRI && wstrb_r[0]
                    && (!wdata_r[PP_SEL_BIT]
                    || wdata_r[PP_PORT_LSB +: 3] == 3'(p))) begin
                port_pri_r[p] <= wdata_r[3:0];
            end
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        rresp_nxt = RESP_OKAY;
        case (s_axi_araddr)
            ADDR_MODE: rdata_nxt[1:0] = mode_r;
            ADDR_WEIGHT: rdata_nxt[15:0] = weight_r;
            ADDR_MAP: rdata_nxt[15:0] = map_r;
            ADDR_PORT_PRI: begin
                for (int p = 0; p < NUM_PORTS; p++) begin
                    rdata_nxt[p*4 +: 4] = port_pri_r[p];
                end
            end
            ADDR_STATUS: begin
                for (int q = 0; q < NUM_Q; q++) begin
                    rdata_nxt[q*4 +: 3] = q_cnt_r[q];
                end
                rdata_nxt[STAT_BUF_LSB +: 2] = buf_cnt_r;
            end
            default: rresp_nxt = RESP_DECERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // classification
    always_comb begin
        if (in_tagged) begin
            in_pri = in_tag_pri;
        end else if (port_pri_r[in_port][PP_EN_BIT]) begin
            in_pri = port_pri_r[in_port][2:0];
        end else begin
            in_pri = 3'h0;
        end
    end
    assign enq_q = map_r[{in_pri, 1'b0} +: 2];
    assign in_ready = q_cnt_r[enq_q] != 3'(Q_DEPTH);
    assign enq_fire = in_valid && in_ready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_r <= '0;
        end else if (enq_fire) begin
            seq_r <= seq_r + 1'b1;
        end
    end

    // transmit queues
    for (genvar g = 0; g < NUM_Q; g++) begin : g_queue
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                q_wp_r[g] <= 2'h0;
                q_rp_r[g] <= 2'h0;
                q_cnt_r[g] <= 3'h0;
            end else begin
                if (enq_fire && enq_q == 2'(g)) begin
                    q_wp_r[g] <= q_wp_r[g] + 1'b1;
                end
                if (deq_fire && sel_q == 2'(g)) begin
                    q_rp_r[g] <= q_rp_r[g] + 1'b1;
                end
                q_cnt_r[g] <= q_cnt_r[g]
                    + 3'(enq_fire && enq_q == 2'(g))
                    - 3'(deq_fire && sel_q == 2'(g));
            end
        end
        always_ff @(posedge aclk) begin
            if (enq_fire && enq_q == 2'(g)) begin
                q_data[g][q_wp_r[g]] <= in_data;
                q_seq[g][q_wp_r[g]] <= seq_r;
            end
        end
        assign q_busy[g] = q_cnt_r[g] != 3'h0;
        assign q_age[g] = seq_r - q_seq[g][q_rp_r[g]];
    end

    // service selection
    always_comb begin
        sel_valid = 1'b0;
        sel_q = Q_LOWEST;
        sel_fresh = 1'b0;
        idx = 2'h0;
        case (mode_r)
            MODE_FCFS: begin
                for (int i = 0; i < NUM_Q; i++) begin
                    if (q_busy[i]
                            && (!sel_valid || q_age[i] > q_age[sel_q])) begin
                        sel_valid = 1'b1;
                        sel_q = 2'(i);
                    end
                end
            end
            MODE_STRICT: begin
                for (int i = 0; i < NUM_Q; i++) begin
                    if (q_busy[i]) begin
                        sel_valid = 1'b1;
                        sel_q = 2'(i);
                    end
                end
            end
            MODE_WRR: begin
                if (q_busy[cur_r]
                        && cnt_r < weight_r[{cur_r, 2'b00} +: 4]) begin
                    sel_valid = 1'b1;
                    sel_q = cur_r;
                end else begin
                    for (int k = 1; k <= NUM_Q; k++) begin
                        idx = cur_r - 2'(k);
                        if (!sel_valid && q_busy[idx]) begin
                            sel_valid = 1'b1;
                            sel_fresh = 1'b1;
                            sel_q = idx;
                        end
                    end
                end
            end
            default: sel_valid = 1'b0;
        endcase
    end
    assign deq_fire = sel_valid && buf_in_ready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_r <= Q_HIGHEST;
            cnt_r <= 4'h0;
        end else if (deq_fire && mode_r == MODE_WRR) begin
            if (sel_fresh) begin
                cur_r <= sel_q;
                cnt_r <= 4'h1;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    // two-entry output buffer
    assign buf_in_ready = buf_cnt_r != 2'(BUF_DEPTH);
    assign out_valid = buf_cnt_r != 2'h0;
    assign out_data = buf_data[buf_rp_r];
    assign out_queue = buf_qid[buf_rp_r];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buf_wp_r <= 1'b0;
            buf_rp_r <= 1'b0;
            buf_cnt_r <= 2'h0;
        end else begin
            if (deq_fire) begin
                buf_wp_r <= !buf_wp_r;
            end
            if (out_valid && out_ready) begin
                buf_rp_r <= !buf_rp_r;
            end
            buf_cnt_r <= buf_cnt_r + 2'(deq_fire) - 2'(out_valid && out_ready);
        end
    end
    always_ff @(posedge aclk) begin
        if (deq_fire) begin
            buf_data[buf_wp_r] <= q_data[sel_q][q_rp_r[sel_q]];
            buf_qid[buf_wp_r] <= sel_q;
        end
    end

    // checks
    a_fcfs_oldest_first: assert property (
        deq_fire && mode_r == MODE_FCFS
        |-> (!q_busy[0] || q_age[0] <= q_age[sel_q])
        && (!q_busy[1] || q_age[1] <= q_age[sel_q])
        && (!q_busy[2] || q_age[2] <= q_age[sel_q])
        && (!q_busy[3] || q_age[3] <= q_age[sel_q]))
        else $error("arrival order broken");
    a_strict_high_first: assert property (
        deq_fire && mode_r == MODE_STRICT
        |-> (q_busy >> (sel_q + 3'h1)) == 4'h0)
        else $error("lower queue served before higher");
    a_wrr_weight_cap: assert property (
        deq_fire && mode_r == MODE_WRR
        |=> cnt_r == 4'h1 || cnt_r <= weight_r[{cur_r, 2'b00} +: 4])
        else $error("queue exceeded weight");
    a_wrr_no_idle: assert property (
        mode_r == MODE_WRR && q_busy != 4'h0 && buf_in_ready |-> deq_fire)
        else $error("idle cycle with waiting packets");
    a_map_lookup: assert property (
        enq_fire && in_tagged
        |=> q_cnt_r[$past(map_r[{in_tag_pri, 1'b0} +: 2])] != 3'h0)
        else $error("tagged packet not queued by map");
    a_untagged_port: assert property (
        in_valid && !in_tagged && port_pri_r[in_port][PP_EN_BIT]
        |-> in_pri == port_pri_r[in_port][2:0])
        else $error("untagged packet ignores port priority");
    a_reset_defaults: assert property (
        $past(!aresetn) |-> mode_r == MODE_WRR && weight_r == 16'h8421
        && map_r == 16'hFA50)
        else $error("wrong defaults after reset");
    a_map_reset_pairs: assert property (
        $past(!aresetn) |-> map_r[1:0] == 2'h0 && map_r[7:6] == 2'h1
        && map_r[15:14] == 2'h3)
        else $error("reset map pairs wrong");
    a_port_all_set: assert property (
        wr_do && awaddr_r == ADDR_PORT_PRI && wstrb_r[0]
        && !wdata_r[PP_SEL_BIT]
        |=> port_pri_r[0] == $past(wdata_r[3:0])
        && port_pri_r[7] == $past(wdata_r[3:0]))
        else $error("unselected port write missed ports");
    a_out_holds: assert property (
        out_valid && !out_ready
        |=> out_valid && $stable(out_data) && $stable(out_queue))
        else $error("output word lost under stall");
    c_fcfs_pop: cover property (deq_fire && mode_r == MODE_FCFS);
    c_strict_pop: cover property (deq_fire && mode_r == MODE_STRICT);
    c_wrr_switch: cover property (deq_fire && sel_fresh);
    c_buf_full: cover property (buf_cnt_r == 2'h2);
endmodule : egress_qos_queue_scheduler

// ---- dv/mac_sink_model.sv ----
`timescale 1ns/1ps
module mac_sink_model
    import qos_sched_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // transmit side
    input wire logic out_valid,
    output logic out_ready,
    input wire logic [DATA_W-1:0] out_data,
    input wire logic [1:0] out_queue,
    // 0 prompt, 1 slow, 2 held off
    input wire logic [1:0] pace
);
    logic [33:0] got[$];

    // captured words are kept for the bench to compare in order
    always @(posedge aclk) begin
        if (!aresetn || pace == 2'h2) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= (pace == 2'h1) ? ~out_ready : 1'b1;
        end
        if (aresetn && out_valid && out_ready) begin
            got.push_back({out_queue, out_data});
        end
    end
endmodule : mac_sink_model

// ---- dv/egress_qos_queue_scheduler_tb.sv ----
`timescale 1ns/1ps
module egress_qos_queue_scheduler_tb;
    import qos_sched_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awv = 1'b0, wv = 1'b0, arv = 1'b0, brdy = 1'b1, rrdy = 1'b1;
    logic awr, wr, bv, arr, rv, irdy, ov, ordy;
    logic [1:0] bresp, rresp, oq;
    logic [1:0] pace = 2'h0;
    logic [31:0] rdata;
    logic [DATA_W-1:0] idata = '0;
    logic [DATA_W-1:0] odata;
    logic iv = 1'b0, itag = 1'b0;
    logic [2:0] ipri = 3'h0, iport = 3'h0;
    logic [33:0] exp_q[$];
    logic [2:0] fpri[8] = '{3'h0, 3'h6, 3'h2, 3'h0, 3'h4, 3'h0, 3'h0, 3'h0};
    logic [7:0] wexp[12] = '{8'h30, 8'h31, 8'h20, 8'h10, 8'h11, 8'h12,
                             8'h00, 8'h32, 8'h33, 8'h21, 8'h13, 8'h01};
    int err_count = 0;
    int comparisons = 0;

    egress_qos_queue_scheduler dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(brdy), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rrdy),
        .in_valid(iv), .in_ready(irdy), .in_data(idata), .in_tagged(itag),
        .in_tag_pri(ipri), .in_port(iport),
        .out_valid(ov), .out_ready(ordy), .out_data(odata), .out_queue(oq)
    );

    mac_sink_model snk_u (
        .aclk(aclk), .aresetn(aresetn), .out_valid(ov), .out_ready(ordy),
        .out_data(odata), .out_queue(oq), .pace(pace)
    );

    initial begin
        forever #4 aclk = ~aclk;
    end

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : do_reset

    // waits only end by the watchdog
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (awv && awr) ad = 1'b1;
            if (wv && wr) dd = 1'b1;
            if (ad) awv <= 1'b0;
            if (dd) wv <= 1'b0;
        end
        do begin
            @(posedge aclk);
        end while (!bv);
        chk({32'h0, bresp}, {32'h0, RESP_OKAY});
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        araddr <= a;
        arv <= 1'b1;
        do begin
            @(posedge aclk);
        end while (!arr);
        arv <= 1'b0;
        do begin
            @(posedge aclk);
        end while (!rv);
        chk({rresp, rdata}, {er, e});
    endtask : rd_reg

    // leaves in_valid up so packets can follow back to back
    task automatic push(input logic t, input logic [2:0] p,
                        input logic [2:0] pt, input logic [31:0] d);
        int n;
        n = 0;
        iv <= 1'b1;
        itag <= t;
        ipri <= p;
        iport <= pt;
        idata <= d;
        do begin
            @(posedge aclk);
            n++;
        end while (!irdy && n < 50);
    endtask : push

    task automatic drain();
        int n;
        n = 0;
        while (snk_u.got.size() < exp_q.size() && n < 500) begin
            @(posedge aclk);
            n++;
        end
        chk(34'(snk_u.got.size()), 34'(exp_q.size()));
        foreach (exp_q[i]) chk(snk_u.got[i], exp_q[i]);
        snk_u.got.delete();
        exp_q.delete();
    endtask : drain

    task automatic complete_run();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        do_reset();
        rd_reg(ADDR_MODE, 32'h2, RESP_OKAY);
        rd_reg(ADDR_WEIGHT, 32'h8421, RESP_OKAY);
        rd_reg(ADDR_MAP, 32'hFA50, RESP_OKAY);
        rd_reg(ADDR_PORT_PRI, 32'h0, RESP_OKAY);
        rd_reg(8'h14, 32'h0, RESP_DECERR);
        wr_reg(ADDR_PORT_PRI, 32'hDE);
        rd_reg(ADDR_PORT_PRI, 32'h00E00000, RESP_OKAY);
        wr_reg(ADDR_PORT_PRI, 32'h0A);
        rd_reg(ADDR_PORT_PRI, 32'hAAAAAAAA, RESP_OKAY);
        wr_reg(ADDR_PORT_PRI, 32'hDE);
        rd_reg(ADDR_PORT_PRI, 32'hAAEAAAAA, RESP_OKAY);
        // strict: two fillers occupy the buffer, rest waits in queues
        wr_reg(ADDR_MODE, 32'h1);
        pace <= 2'h2;
        push(1'b1, 3'h7, 3'h0, 32'hF0);
        push(1'b1, 3'h7, 3'h0, 32'hF1);
        push(1'b1, 3'h0, 3'h0, 32'hD0);
        push(1'b1, 3'h2, 3'h0, 32'hD1);
        push(1'b0, 3'h0, 3'h5, 32'hD2);
        push(1'b0, 3'h0, 3'h1, 32'hD3);
        push(1'b1, 3'h4, 3'h0, 32'hD4);
        iv <= 1'b0;
        pace <= 2'h0;
        exp_q = '{{2'h3, 32'hF0}, {2'h3, 32'hF1}, {2'h3, 32'hD2},
                  {2'h2, 32'hD4}, {2'h1, 32'hD1}, {2'h1, 32'hD3},
                  {2'h0, 32'hD0}};
        drain();
        // arrival order, lowest queue filled until refused
        wr_reg(ADDR_MODE, 32'h0);
        pace <= 2'h2;
        for (int i = 0; i < 8; i++) begin
            push(1'b1, fpri[i], 3'h0, 32'hA0 + 32'(i));
            exp_q.push_back({fpri[i][2:1], 32'hA0 + 32'(i)});
        end
        iv <= 1'b0;
        ipri <= 3'h0;
        @(posedge aclk);
        chk({33'h0, irdy}, 34'h0);
        ipri <= 3'h7;
        @(posedge aclk);
        chk({33'h0, irdy}, 34'h1);
        // counts: lowest 4, second low 1, second high 1, buffer 2
        rd_reg(ADDR_STATUS, 32'h00020114, RESP_OKAY);
        pace <= 2'h0;
        drain();
        // second reset, then weighted service with a slow receiver
        do_reset();
        rd_reg(ADDR_MODE, 32'h2, RESP_OKAY);
        // weights 2,1,3,1 from highest to lowest queue
        wr_reg(ADDR_WEIGHT, 32'h2131);
        pace <= 2'h2;
        for (int q = 3; q >= 0; q--) begin
            for (int k = 0; k < ((q % 2) ? 4 : 2); k++) begin
                push(1'b1, {q[1:0], 1'b1}, 3'h0, 32'(q * 16 + k));
            end
        end
        iv <= 1'b0;
        pace <= 2'h1;
        foreach (wexp[i]) exp_q.push_back({wexp[i][5:4], 24'h0, wexp[i]});
        drain();
        // level 0 keeps the lowest queue, levels 1..7 move
        wr_reg(ADDR_MAP, 32'h05AC);
        rd_reg(ADDR_MAP, 32'h05AC, RESP_OKAY);
        push(1'b1, 3'h1, 3'h0, 32'hBB);
        iv <= 1'b0;
        exp_q.push_back({2'h3, 32'hBB});
        drain();
        complete_run();
    end

    initial begin
        repeat (5000) @(posedge aclk);
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule : egress_qos_queue_scheduler_tb
